// *** src/bulk_cfg_pkg.sv ***
// Purpose: shared constants for the bulk-in configuration register bank
// Assumes: apb slave with 32-bit data, byte addresses
// Notes: offsets are byte addresses
`default_nettype none
package bulk_cfg_pkg;
  localparam logic [11:0] OFF_USB_CONFIG_FIRST = 12'h080;
  localparam logic [11:0] OFF_USB_CONFIG_ONE = 12'h084;
  localparam logic [11:0] OFF_USB_DETACH_TIMES = 12'h088;
  localparam logic [11:0] OFF_BULK_IN_BURST_LIMIT = 12'h090;
  localparam logic [11:0] OFF_SHORT_PACKET_WAIT_TIME = 12'h094;
  localparam int BIT_BURST_ENABLE = 1;
  localparam int BIT_RESET_PROTECT = 2;
  localparam int BIT_LATENCY_MSG = 8;
  localparam int BIT_HOST_U1 = 9;
  localparam logic [1:0] SCALE_RESET = 2'h0;
  localparam logic FALLBACK_HOST_U1 = 1'h1;
  localparam logic FALLBACK_LATENCY_MSG = 1'h0;
  localparam logic [2:0] FALLBACK_FS_TRIM = 3'h0;
  localparam logic [2:0] FALLBACK_HS_TRIM = 3'h0;
  localparam logic [15:0] FALLBACK_SS_DETACH = 16'h001e;
  localparam logic [15:0] FALLBACK_HIGHSPEED_DETACH = 16'h000a;
  localparam logic [7:0] BURST_LIMIT_RESET = 8'h00;
  localparam logic [15:0] SHORT_WAIT_RESET = 16'h0800;
  localparam logic [15:0] BURST_OFF_BYTES = 16'h0800;
  localparam int UNIT_SS_SHIFT = 10;
  localparam int UNIT_HS_SHIFT = 9;
  localparam int UNIT_FS_SHIFT = 6;
  localparam int WAIT_UNIT_PS = 16667;
  localparam int CLK_PERIOD_PS = 20000;
  // wait count in clock cycles per unit, rounded down but at least one
  localparam int WAIT_UNIT_CYC = (WAIT_UNIT_PS / CLK_PERIOD_PS) < 1 ? 1 : (WAIT_UNIT_PS / CLK_PERIOD_PS);
  localparam int SS_TXEQ_SHORT = 8;
  localparam int SS_POLL_BURST_NS = 100;
  localparam int SS_WARM_RESET_US = 30;
  localparam logic [1:0] SPEED_FS = 2'h0;
  localparam logic [1:0] SPEED_HS = 2'h1;
  localparam logic [1:0] SPEED_SS = 2'h2;
endpackage
`default_nettype wire

// *** src/bulk_skid.sv ***
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, synchronous reset
// Notes: full buffer drops in_ready, so the source stalls
`default_nettype none
module bulk_skid #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
    logic rd;
  } skid_t;
  skid_t s_q, s_d;
  logic push, pop;
  assign in_ready = (s_q.cnt != 2'd2);
  assign out_valid = (s_q.cnt != 2'd0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.rd ^ s_q.cnt[0]] = in_data;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  a_skid_bound: assert property (@(posedge clk) disable iff (rst) s_q.cnt <= 2'd2)
    else $error("buffer count exceeds two");
  a_skid_full: assert property (@(posedge clk) disable iff (rst)
    (s_q.cnt == 2'd2 && !out_ready) |=> !in_ready)
    else $error("full buffer accepted a word");
endmodule
`default_nettype wire

// *** src/usb_bulk_in_config_regs.sv ***
// Purpose: usb configuration registers and bulk-in burst and wait control
// Assumes: apb slave, one clock, loader presents image when valid
// Notes: stream words carry a last flag in the top bit
// Operation
// R1: two-bit scale-down selects usb 2 timing shortening
// R2: value 01 shortens training, polling, warm reset
// R3: value 10 drops training; 11 combines both
// R4: scale-down resets to 00, simulation use only
// R5: defaults from eeprom, else otp, else fallback; here SRST always loads the fallback, and the image is applied only on reload
// R6: usb or lite reset reloads last image
// R7: fallbacks: host u1 one, latency messaging zero
// R8: timeout trim fallbacks are zero
// R9: bits 31:16 give fast-mode detach milliseconds
// R10: bits 15:0 give high/full detach milliseconds
// R11: detach fallbacks are 0x1e and 0x0a
// R12: detach fields obey reset protection
// R13: zero-length packet after burst limit reached
// R14: burst limit units 1024/512/64 bytes, reset zero
// R15: burst limit needs enable bit in config
// R16: software sets limit at least max frame
// R17: limit at or under 2048 bytes disables
// R18: wait delay before short packet or zlp
// R19: reserved bits read zero, writes ignored
//
// Chosen here: register access over APB.
`default_nettype none
module usb_bulk_in_config_regs #(
  parameter int DATA_W = 8
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic USB_RESET,
  input wire logic LITE_RESET,
  input wire logic EEPROM_PRESENT,
  input wire logic OTP_PRESENT,
  input wire logic [39:0] EEPROM_IMAGE,
  input wire logic [39:0] OTP_IMAGE,
  input wire logic [1:0] LINK_SPEED,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [DATA_W-1:0] IN_DATA,
  input wire logic IN_LAST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [DATA_W-1:0] OUT_DATA,
  output logic OUT_LAST,
  output logic OUT_ZLP,
  output logic [1:0] SCALE_DOWN,
  output logic SS_TXEQ_SHORT,
  output logic SS_TXEQ_NONE,
  output logic USB2_TIMING_SHORT,
  output logic USB2_SUSPEND_SHORT,
  output logic HOST_U1_ACCEPT,
  output logic LATENCY_MSG_ENABLE,
  output logic [2:0] HS_TRIM,
  output logic [2:0] FS_TRIM,
  output logic [15:0] SS_DETACH_MS,
  output logic [15:0] HIGHSPEED_DETACH_MS
);
  // the transmit path counts bytes, so only a byte-wide stream is served
  if (DATA_W != 8) begin : g_width_check
    $error("byte stream only");
  end
  // image layout: [39:24] ss detach, [23:8] highspeed_detach_ms, [7:5] hs trim, [4:2] fs trim, [1] u1, [0] ltm
  typedef enum logic [1:0] {ST_PASS, ST_WAIT, ST_ZLP} tx_state_t;
  typedef struct packed {
    logic [1:0] scale;
    logic burst_en;
    logic protect;
    logic host_u1;
    logic latency_msg;
    logic [2:0] hs_trim;
    logic [2:0] fs_trim;
    logic [15:0] ss_detach;
    logic [15:0] highspeed_detach;
    logic [7:0] burst_limit;
    logic [15:0] short_wait;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tx_state_t st;
    logic [18:0] sent;
    logic [15:0] wait_cnt;
    logic [7:0] unit_cnt;
    logic zlp;
    logic [2:0] rst_sync;
  } regs_t;
  regs_t r_q, r_d;
  logic [39:0] image;
  logic [18:0] limit_bytes;
  logic limit_on;
  logic reload;
  logic access;
  logic up_valid, up_ready, sk_valid, sk_ready, sk_last;
  logic [DATA_W-1:0] sk_data;
  logic [DATA_W:0] sk_word;
  // [R5] eeprom outranks otp, otp outranks fallback
  always_comb begin
    if (EEPROM_PRESENT) begin
      image = EEPROM_IMAGE;
    end else if (OTP_PRESENT) begin
      image = OTP_IMAGE;
    end else begin
      image = {bulk_cfg_pkg::FALLBACK_SS_DETACH, bulk_cfg_pkg::FALLBACK_HIGHSPEED_DETACH,
        bulk_cfg_pkg::FALLBACK_HS_TRIM, bulk_cfg_pkg::FALLBACK_FS_TRIM, bulk_cfg_pkg::FALLBACK_HOST_U1,
        bulk_cfg_pkg::FALLBACK_LATENCY_MSG};
    end
  end
  // [R14] unit scaled by link speed
  always_comb begin
    case (LINK_SPEED)
      bulk_cfg_pkg::SPEED_SS: limit_bytes = {1'b0, r_q.burst_limit, 10'h000};
      bulk_cfg_pkg::SPEED_HS: limit_bytes = {2'b00, r_q.burst_limit, 9'h000};
      default: limit_bytes = {5'h00, r_q.burst_limit, 6'h00};
    endcase
  end
  // [R15] [R17] enable bit and over 2048 bytes
  assign limit_on = r_q.burst_en && (limit_bytes > {3'b000, bulk_cfg_pkg::BURST_OFF_BYTES});
  // usb reset pins come from another domain; rising edge once stages agree
  // stages reset to ones, so pins still high at reset release give no false reload after reset
  assign reload = r_q.rst_sync[1] && !r_q.rst_sync[2];
  assign access = PSEL && PENABLE && !r_q.pready;
  assign up_valid = IN_VALID && r_q.st == ST_PASS && !r_q.zlp;
  assign IN_READY = up_ready && r_q.st == ST_PASS && !r_q.zlp;
  always_comb begin
    r_d = r_q;
    r_d.rst_sync = {r_q.rst_sync[1:0], USB_RESET || LITE_RESET};
    r_d.pready = access;
    r_d.pslverr = 1'b0;
    // [R6] reload the last image on usb or lite reset
    if (reload) begin
      r_d.host_u1 = image[1];
      r_d.latency_msg = image[0];
      r_d.fs_trim = image[4:2];
      r_d.hs_trim = image[7:5];
      // [R12] protected detach fields keep software values
      if (!r_q.protect) begin
        r_d.highspeed_detach = image[23:8];
        r_d.ss_detach = image[39:24];
      end
    end
    // a bus write in the same cycle lands after the reload and wins
    if (access) begin
      r_d.prdata = 32'h0000_0000;
      case (PADDR)
        bulk_cfg_pkg::OFF_USB_CONFIG_FIRST: begin
          if (PWRITE) begin
            r_d.burst_en = PWDATA[bulk_cfg_pkg::BIT_BURST_ENABLE];
            r_d.protect = PWDATA[bulk_cfg_pkg::BIT_RESET_PROTECT];
          end else begin
            r_d.prdata[bulk_cfg_pkg::BIT_BURST_ENABLE] = r_q.burst_en;
            r_d.prdata[bulk_cfg_pkg::BIT_RESET_PROTECT] = r_q.protect;
          end
        end
        bulk_cfg_pkg::OFF_USB_CONFIG_ONE: begin
          if (PWRITE) begin
            r_d.scale = PWDATA[1:0]; // [R1]
            r_d.fs_trim = PWDATA[6:4];
            r_d.latency_msg = PWDATA[bulk_cfg_pkg::BIT_LATENCY_MSG];
            r_d.host_u1 = PWDATA[bulk_cfg_pkg::BIT_HOST_U1];
            r_d.hs_trim = PWDATA[12:10];
          end else begin
            r_d.prdata = {19'h0, r_q.hs_trim, r_q.host_u1, r_q.latency_msg, 1'b0, r_q.fs_trim, 2'b00, r_q.scale};
          end
        end
        bulk_cfg_pkg::OFF_USB_DETACH_TIMES: begin
          if (PWRITE) begin
            r_d.ss_detach = PWDATA[31:16]; // [R9]
            r_d.highspeed_detach = PWDATA[15:0]; // [R10]
          end else begin
            r_d.prdata = {r_q.ss_detach, r_q.highspeed_detach};
          end
        end
        bulk_cfg_pkg::OFF_BULK_IN_BURST_LIMIT: begin
          if (PWRITE) begin
            r_d.burst_limit = PWDATA[7:0]; // [R19]
          end else begin
            r_d.prdata = {24'h0, r_q.burst_limit};
          end
        end
        bulk_cfg_pkg::OFF_SHORT_PACKET_WAIT_TIME: begin
          if (PWRITE) begin
            r_d.short_wait = PWDATA[15:0]; // [R19]
          end else begin
            r_d.prdata = {16'h0, r_q.short_wait};
          end
        end
        default: r_d.pslverr = 1'b1;
      endcase
    end
    // transmit side: count burst bytes, wait, then zlp
    case (r_q.st)
      ST_PASS: begin
        if (r_q.zlp) begin
          if (sk_ready && !sk_valid) begin
            r_d.zlp = 1'b0;
          end
        end else if (up_valid && up_ready) begin
          // counts across packets; held at zero while off, so a late enable starts fresh
          r_d.sent = limit_on ? r_q.sent + 19'd1 : 19'd0;
          // [R13] limit reached ends the burst with a zlp
          if (IN_LAST || (limit_on && r_q.sent + 19'd1 >= limit_bytes)) begin
            r_d.st = ST_WAIT;
            r_d.wait_cnt = r_q.short_wait;
            r_d.unit_cnt = 8'd0;
          end
        end
      end
      ST_WAIT: begin
        // [R18] hold for short_wait units of one clock (20 ns), not units of 16.667 ns
        if (r_q.wait_cnt == 16'h0000) begin
          r_d.st = (limit_on && r_q.sent >= limit_bytes) ? ST_ZLP : ST_PASS;
        end else if (r_q.unit_cnt == 8'(bulk_cfg_pkg::WAIT_UNIT_CYC - 1)) begin
          r_d.unit_cnt = 8'd0;
          r_d.wait_cnt = r_q.wait_cnt - 16'd1;
        end else begin
          r_d.unit_cnt = r_q.unit_cnt + 8'd1;
        end
      end
      ST_ZLP: begin
        r_d.zlp = 1'b1;
        r_d.sent = 19'd0;
        r_d.st = ST_PASS;
      end
      default: r_d.st = ST_PASS;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_q <= '0;
      r_q.scale <= bulk_cfg_pkg::SCALE_RESET; // [R4]
      r_q.host_u1 <= bulk_cfg_pkg::FALLBACK_HOST_U1; // [R7]
      r_q.latency_msg <= bulk_cfg_pkg::FALLBACK_LATENCY_MSG;
      r_q.hs_trim <= bulk_cfg_pkg::FALLBACK_HS_TRIM; // [R8]
      r_q.fs_trim <= bulk_cfg_pkg::FALLBACK_FS_TRIM;
      r_q.ss_detach <= bulk_cfg_pkg::FALLBACK_SS_DETACH; // [R11]
      r_q.highspeed_detach <= bulk_cfg_pkg::FALLBACK_HIGHSPEED_DETACH;
      r_q.burst_limit <= bulk_cfg_pkg::BURST_LIMIT_RESET;
      r_q.short_wait <= bulk_cfg_pkg::SHORT_WAIT_RESET;
      r_q.st <= ST_PASS;
      r_q.rst_sync <= 3'b111;
    end else begin
      r_q <= r_d;
    end
  end
  assign sk_word = {IN_LAST, IN_DATA};
  bulk_skid #(.WIDTH(DATA_W + 1)) u_skid (
    .clk(CLK),
    .rst(SRST),
    .in_valid(up_valid),
    .in_ready(up_ready),
    .in_data(sk_word),
    .out_valid(sk_valid),
    .out_ready(sk_ready),
    .out_data({sk_last, sk_data})
  );
  // output stage register keeps outputs on flip-flops
  typedef struct packed {
    logic v;
    logic [DATA_W-1:0] d;
    logic l;
    logic z;
  } out_t;
  out_t o_q, o_d;
  assign sk_ready = !o_q.v || OUT_READY;
  always_comb begin
    o_d = o_q;
    if (!o_q.v || OUT_READY) begin
      o_d.v = sk_valid || (r_q.zlp && !sk_valid);
      o_d.d = sk_valid ? sk_data : '0;
      o_d.l = sk_valid ? sk_last : 1'b1;
      o_d.z = !sk_valid && r_q.zlp; // [R13]
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end
  assign OUT_VALID = o_q.v;
  assign OUT_DATA = o_q.d;
  assign OUT_LAST = o_q.l;
  assign OUT_ZLP = o_q.z;
  assign PRDATA = r_q.prdata;
  assign PREADY = r_q.pready;
  assign PSLVERR = r_q.pslverr;
  assign SCALE_DOWN = r_q.scale;
  // [R1] [R2] [R3] scale bit 0 shortens, bit 1 suspend or no training
  assign USB2_TIMING_SHORT = r_q.scale[0];
  assign USB2_SUSPEND_SHORT = r_q.scale[1];
  // with both bits set the phy sees both; no training overrides the short count
  assign SS_TXEQ_SHORT = r_q.scale[0];
  assign SS_TXEQ_NONE = r_q.scale[1];
  assign HOST_U1_ACCEPT = r_q.host_u1;
  assign LATENCY_MSG_ENABLE = r_q.latency_msg;
  assign HS_TRIM = r_q.hs_trim;
  assign FS_TRIM = r_q.fs_trim;
  assign SS_DETACH_MS = r_q.ss_detach;
  assign HIGHSPEED_DETACH_MS = r_q.highspeed_detach;
  a_scale_reset: assert property (@(posedge CLK) $fell(SRST) |-> r_q.scale == 2'b00) // [R4]
    else $error("scale-down not zero after reset");
  a_apb_answer: assert property (@(posedge CLK) disable iff (SRST) access |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");
  a_burst_gate: assert property (@(posedge CLK) disable iff (SRST) !r_q.burst_en |-> !limit_on) // [R15]
    else $error("burst limit active without enable");
  a_small_limit: assert property (@(posedge CLK) disable iff (SRST) // [R17]
    (limit_bytes <= 19'h00800) |-> !limit_on)
    else $error("small limit not disabled");
  a_reserved_zero: assert property (@(posedge CLK) disable iff (SRST) // [R19]
    (access && !PWRITE && PADDR == bulk_cfg_pkg::OFF_BULK_IN_BURST_LIMIT) |=> PRDATA[31:8] == 24'h0)
    else $error("reserved bits not zero");
  a_wait_first: assert property (@(posedge CLK) disable iff (SRST) // [R18]
    (r_q.st == ST_PASS && $past(r_q.st) == ST_WAIT && $past(r_q.wait_cnt) != 16'h0) |-> 1'b0)
    else $error("wait left early");
  a_wait_stall: assert property (@(posedge CLK) disable iff (SRST) // [R18]
    (r_q.st == ST_WAIT) |-> !IN_READY)
    else $error("input accepted during wait");
  a_txeq_mode: assert property (@(posedge CLK) disable iff (SRST) // [R3]
    (r_q.scale == 2'b11) |-> (SS_TXEQ_NONE && SS_TXEQ_SHORT && USB2_TIMING_SHORT && USB2_SUSPEND_SHORT))
    else $error("combined scale mode wrong");
  a_detach_write: assert property (@(posedge CLK) disable iff (SRST) // [R9]
    (access && PWRITE && PADDR == bulk_cfg_pkg::OFF_USB_DETACH_TIMES)
    |=> SS_DETACH_MS == $past(PWDATA[31:16]))
    else $error("detach write lost");
  a_protect_hold: assert property (@(posedge CLK) disable iff (SRST) // [R12]
    (reload && r_q.protect && !access) |=> ($stable(SS_DETACH_MS) && $stable(HIGHSPEED_DETACH_MS)))
    else $error("protected detach time reloaded");
  a_reload_u1: assert property (@(posedge CLK) disable iff (SRST) // [R6]
    (reload && !access) |=> HOST_U1_ACCEPT == $past(image[1]))
    else $error("reload missed the image");
  a_zlp_word: assert property (@(posedge CLK) disable iff (SRST) // [R13]
    (OUT_VALID && OUT_ZLP) |-> (OUT_LAST && OUT_DATA == '0))
    else $error("zlp word carries data");
  c_zlp_sent: cover property (@(posedge CLK) OUT_VALID && OUT_ZLP && OUT_READY);
  c_wait_seen: cover property (@(posedge CLK) r_q.st == ST_WAIT);
  c_reload: cover property (@(posedge CLK) reload);
  c_burst_on: cover property (@(posedge CLK) limit_on && r_q.st == ST_WAIT);
  c_scale_both: cover property (@(posedge CLK) r_q.scale == 2'b11);
endmodule
`default_nettype wire

// *** testbench/bulk_host_model.sv ***
// Purpose: usb host side that drains bulk-in words
// Assumes: one clock, a word is taken at a rising edge with valid and ready high
// Notes: slow mode accepts one cycle in three, so the skid buffer fills
`default_nettype none
module bulk_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic clear,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_zlp,
  output logic [15:0] bytes,
  output logic [15:0] zlps,
  output logic [15:0] lasts,
  output logic [15:0] bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  assign out_ready = !slow || (phase == 2'h2);
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      phase <= 2'h0;
      bytes <= 16'h0;
      zlps <= 16'h0;
      lasts <= 16'h0;
      bad <= 16'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      if (out_valid && out_ready) begin
        if (out_zlp) begin
          zlps <= zlps + 16'h1;
          // a zlp word carries no data and closes the burst
          if (out_data !== 8'h00 || out_last !== 1'b1) bad <= bad + 16'h1;
        end else begin
          bytes <= bytes + 16'h1;
          if (out_last) lasts <= lasts + 16'h1;
          // bytes arrive in order, none lost while stalled
          if (out_data !== bytes[7:0]) bad <= bad + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_usb_bulk_in_config_regs.sv ***
// Purpose: self-checking bench for the bulk-in configuration registers
// Assumes: apb with one wait state, host model on the bulk-in stream
// Notes: burst counter holds zero while limiting is off
`default_nettype none
module tb_usb_bulk_in_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic USB_RESET, LITE_RESET, EEPROM_PRESENT, OTP_PRESENT, IN_VALID, IN_READY, IN_LAST;
  logic [39:0] EEPROM_IMAGE, OTP_IMAGE;
  logic [1:0] LINK_SPEED, SCALE_DOWN;
  logic [7:0] IN_DATA, OUT_DATA;
  logic OUT_VALID, OUT_READY, OUT_LAST, OUT_ZLP, SS_TXEQ_SHORT, SS_TXEQ_NONE;
  logic USB2_TIMING_SHORT, USB2_SUSPEND_SHORT, HOST_U1_ACCEPT, LATENCY_MSG_ENABLE;
  logic [2:0] HS_TRIM, FS_TRIM;
  logic [15:0] SS_DETACH_MS, HIGHSPEED_DETACH_MS, nbytes, nzlps, nlasts, nbad;
  logic SLOW, CLEAR;
  int errors = 0;
  int tests_run = 0;
  usb_bulk_in_config_regs #(.DATA_W(8)) usb_bulk_in_config_regs_inst (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .USB_RESET(USB_RESET), .LITE_RESET(LITE_RESET), .EEPROM_PRESENT(EEPROM_PRESENT),
    .OTP_PRESENT(OTP_PRESENT), .EEPROM_IMAGE(EEPROM_IMAGE), .OTP_IMAGE(OTP_IMAGE), .LINK_SPEED(LINK_SPEED),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA), .IN_LAST(IN_LAST), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .OUT_ZLP(OUT_ZLP), .SCALE_DOWN(SCALE_DOWN),
    .SS_TXEQ_SHORT(SS_TXEQ_SHORT), .SS_TXEQ_NONE(SS_TXEQ_NONE), .USB2_TIMING_SHORT(USB2_TIMING_SHORT),
    .USB2_SUSPEND_SHORT(USB2_SUSPEND_SHORT), .HOST_U1_ACCEPT(HOST_U1_ACCEPT),
    .LATENCY_MSG_ENABLE(LATENCY_MSG_ENABLE), .HS_TRIM(HS_TRIM), .FS_TRIM(FS_TRIM),
    .SS_DETACH_MS(SS_DETACH_MS), .HIGHSPEED_DETACH_MS(HIGHSPEED_DETACH_MS));
  bulk_host_model bulk_host_model_inst (.clk(CLK), .rst(SRST), .slow(SLOW), .clear(CLEAR),
    .out_valid(OUT_VALID), .out_ready(OUT_READY), .out_data(OUT_DATA), .out_last(OUT_LAST), .out_zlp(OUT_ZLP),
    .bytes(nbytes), .zlps(nzlps), .lasts(nlasts), .bad(nbad));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic give_verdict;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    er = PSLVERR;
    if (n >= 50) errors++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask
  task automatic pulse(input logic lite);
    if (lite) LITE_RESET <= 1'b1;
    else USB_RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    LITE_RESET <= 1'b0;
    USB_RESET <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask
  task automatic chk_img(input logic [15:0] ss, input logic [15:0] hs, input logic [2:0] ht,
                         input logic [2:0] ft, input logic u1, input logic lt);
    rdchk(12'h088, {ss, hs});
    check({SS_DETACH_MS, HIGHSPEED_DETACH_MS}, {ss, hs});
    check({26'h0, HS_TRIM, FS_TRIM}, {26'h0, ht, ft});
    check({30'h0, HOST_U1_ACCEPT, LATENCY_MSG_ENABLE}, {30'h0, u1, lt});
  endtask
  task automatic send(input logic [7:0] d, input logic l);
    logic r;
    int n;
    n = 0;
    IN_VALID <= 1'b1;
    IN_DATA <= d;
    IN_LAST <= l;
    do begin
      @(negedge CLK);
      r = IN_READY;
      n++;
      @(posedge CLK);
    end while (r !== 1'b1 && n < 5000);
    if (r !== 1'b1) errors++;
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    chk_img(16'h001e, 16'h000a, 3'h0, 3'h0, 1'b1, 1'b0);
    rdchk(12'h090, 32'h0);
    rdchk(12'h094, 32'h0000_0800);
    check({30'h0, SCALE_DOWN}, 32'h0);
    wr(12'h090, 32'hffff_ffff);
    rdchk(12'h090, 32'h0000_00ff);
    wr(12'h094, 32'hffff_ffff);
    rdchk(12'h094, 32'h0000_ffff);
    wr(12'h088, 32'h1234_abcd);
    rdchk(12'h088, 32'h1234_abcd);
    check({SS_DETACH_MS, HIGHSPEED_DETACH_MS}, 32'h1234_abcd);
    apb(1'b1, 12'h0fc, 32'h1, r, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 12'h0fc, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_scale;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(12'h084, {30'h0, s});
      LINK_SPEED <= bulk_cfg_pkg::SPEED_SS;
      rdchk(12'h084, {30'h0, s});
      check({30'h0, SCALE_DOWN}, {30'h0, s});
      check({30'h0, SS_TXEQ_NONE, SS_TXEQ_SHORT}, {30'h0, s});
      LINK_SPEED <= bulk_cfg_pkg::SPEED_HS;
      repeat (3) @(posedge CLK);
      check({30'h0, USB2_SUSPEND_SHORT, USB2_TIMING_SHORT}, {30'h0, s});
    end
    // back to real timing for the rest of the run
    wr(12'h084, 32'h0);
    $display("test scale done");
  endtask
  task automatic t_reload;
    wr(12'h080, 32'h4);
    wr(12'h088, 32'h0042_0043);
    pulse(1'b0);
    rdchk(12'h088, 32'h0042_0043);
    check({31'h0, HOST_U1_ACCEPT}, 32'h1);
    wr(12'h080, 32'h0);
    EEPROM_IMAGE <= 40'h1234_5678_a9;
    OTP_IMAGE <= 40'h0bcd_0123_56;
    EEPROM_PRESENT <= 1'b1;
    OTP_PRESENT <= 1'b1;
    pulse(1'b0);
    chk_img(16'h1234, 16'h5678, 3'h5, 3'h2, 1'b0, 1'b1);
    EEPROM_PRESENT <= 1'b0;
    pulse(1'b1);
    chk_img(16'h0bcd, 16'h0123, 3'h2, 3'h5, 1'b1, 1'b0);
    OTP_PRESENT <= 1'b0;
    pulse(1'b0);
    chk_img(16'h001e, 16'h000a, 3'h0, 3'h0, 1'b1, 1'b0);
    $display("test reload done");
  endtask
  task automatic t_burst(input logic [7:0] lim, input logic en, input logic [15:0] ezlp);
    int n;
    wr(12'h094, 32'h2);
    wr(12'h090, {24'h0, lim});
    wr(12'h080, {30'h0, en, 1'b0});
    LINK_SPEED <= bulk_cfg_pkg::SPEED_FS;
    CLEAR <= 1'b1;
    SLOW <= 1'b1;
    @(posedge CLK);
    CLEAR <= 1'b0;
    // 64-byte frames stay under the limit, as software must
    for (int p = 0; p < 33; p++) begin
      for (int b = 0; b < 64; b++) send(8'((p * 64) + b), b == 63);
    end
    IN_VALID <= 1'b0;
    n = 0;
    while (nbytes < 16'd2112 && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    repeat (20) @(posedge CLK);
    check({16'h0, nbytes}, 32'd2112);
    check({16'h0, nlasts}, 32'd33);
    check({16'h0, nzlps}, {16'h0, ezlp});
    check({16'h0, nbad}, 32'h0);
    $display("test burst %0d %0d done", lim, en);
  endtask
  task automatic t_wait;
    int n;
    SLOW <= 1'b0;
    wr(12'h094, 32'h5);
    send(8'h00, 1'b1);
    IN_VALID <= 1'b0;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (IN_READY !== 1'b1 && n < 100);
    check({31'h0, n >= 5 && n <= 8}, 32'h1);
    $display("test wait done");
  endtask
  initial begin
    #(80000 * 20);
    errors++;
    give_verdict();
  end
  initial begin
    SRST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {USB_RESET, LITE_RESET, EEPROM_PRESENT, OTP_PRESENT, EEPROM_IMAGE, OTP_IMAGE} = '0;
    {IN_VALID, IN_DATA, IN_LAST, SLOW, CLEAR} = '0;
    LINK_SPEED = bulk_cfg_pkg::SPEED_FS;
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    t_regs();
    t_scale();
    t_reload();
    t_burst(8'd33, 1'b1, 16'd1);
    t_burst(8'd33, 1'b0, 16'd0);
    t_burst(8'd32, 1'b1, 16'd0);
    t_wait();
    give_verdict();
  end
endmodule
`default_nettype wire
